// file: core/mqf_pkg.sv
// Shared constants and types for the multi-queue status flag logic.
package mqf_pkg;

  // ==========================================================
  // Sizes
  localparam int NQ = 8;
  localparam int QW = 3;
  localparam int CNT_W = 20;
  localparam int OFS_W = 16;

  // ==========================================================
  // Almost-empty offsets used when nothing is programmed
  localparam logic [OFS_W-1:0] OFS_LOW = 16'h0008;
  localparam logic [OFS_W-1:0] OFS_HIGH = 16'h0080;
  // Slack between offset and boundary, in 36-bit words (four 9-bit units).
  localparam logic [CNT_W-1:0] SLACK_WONLY = 20'h00001;
  localparam logic [CNT_W-1:0] SLACK_BOTH = 20'h00002;

  // ==========================================================
  // Flag latencies in read-clock cycles after the causing edge
  localparam int AE_LAT = 2;
  localparam int PR_LAT = 3;
  localparam int AF_SEL_LAT = 1;

  // ==========================================================
  // Bus width pairings, fixed at master reset
  typedef enum logic [2:0] {
    MQF_W36_36,
    MQF_W36_18,
    MQF_W36_9,
    MQF_W18_36,
    MQF_W9_36
  } mqf_width_t;

  // Fill is counted in 9-bit units.
  localparam logic [2:0] UNITS_36 = 3'h4;
  localparam logic [2:0] UNITS_18 = 3'h2;
  localparam logic [2:0] UNITS_9 = 3'h1;

  // ==========================================================
  // Avalon register map (byte addresses) and field positions
  localparam logic [3:0] REG_AE_OFFSET = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int OFS_LOADED_BIT = 16;
  localparam int STS_BUS_LSB = 0;
  localparam int STS_ACT_LSB = 8;
  localparam int STS_RDQ_LSB = 11;
  localparam int STS_WRQ_LSB = 14;
  localparam int STS_CFG_LSB = 17;
  localparam int STS_AFOE_BIT = 20;

endpackage : mqf_pkg

// file: core/mqf_queue_flags.sv
// Fill and packet tracking for one queue, feeding the flag pipelines.
`timescale 1ns/1ns
`default_nettype none
module mqf_queue_flags
(
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_clr,
  // Write side
  input wire logic i_wr,
  input wire logic [2:0] i_wr_units,
  input wire logic i_sop_wr,
  input wire logic i_eop_wr,
  input wire logic i_both_sel,
  // Read side
  input wire logic i_rd,
  input wire logic [2:0] i_rd_units,
  input wire logic i_sop_rd,
  // Boundaries in 9-bit units
  input wire logic [mqf_pkg::CNT_W-1:0] i_thr_both,
  input wire logic [mqf_pkg::CNT_W-1:0] i_thr_wonly,
  // Flag pipeline taps, high means the flag is inactive
  output logic o_ae_pre,
  output logic o_pr_pre
);
  import mqf_pkg::*;

  logic [CNT_W-1:0] lvl_q;
  logic [CNT_W-1:0] thr;
  logic first_both_q;
  logic open_q;
  logic [CNT_W-1:0] pkts_q;
  logic pkt_in;
  logic pkt_out;
  logic pr_s1_q;

  assign thr = first_both_q ? i_thr_both : i_thr_wonly;
  assign pkt_in = i_wr && i_eop_wr && open_q;
  assign pkt_out = i_rd && i_sop_rd && (pkts_q != '0);

  // ==========================================================
  // Fill level
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_clr)
      lvl_q <= '0;
    else if (i_rd && (lvl_q < CNT_W'(i_rd_units)))
      lvl_q <= i_wr ? CNT_W'(i_wr_units) : '0;
    else
      lvl_q <= lvl_q + (i_wr ? CNT_W'(i_wr_units) : '0)
               - (i_rd ? CNT_W'(i_rd_units) : '0);
  end

  // The boundary depends on who watched the queue at its first word.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_clr)
      first_both_q <= 1'b0;
    else if (i_wr && (lvl_q == '0))
      first_both_q <= i_both_sel;
  end

  // One stage here plus the output stage gives two cycles both ways.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_ae_pre <= 1'b0;
    else
      o_ae_pre <= (lvl_q >= thr);
  end

  // ==========================================================
  // Packet accounting
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_clr)
      open_q <= 1'b0;
    else if (i_wr && i_eop_wr)
      open_q <= 1'b0;
    else if (i_wr && i_sop_wr)
      open_q <= 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_clr)
      pkts_q <= '0;
    else if (pkt_in && !pkt_out)
      pkts_q <= pkts_q + CNT_W'(1);
    else if (pkt_out && !pkt_in)
      pkts_q <= pkts_q - CNT_W'(1);
  end

  // Two stages here plus the output stage gives three cycles.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pr_s1_q <= 1'b1;
      o_pr_pre <= 1'b1;
    end
    else
    begin
      pr_s1_q <= (pkts_q == '0);
      o_pr_pre <= pr_s1_q;
    end
  end

  // ==========================================================
  // Checks
  first_sel_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_wr && !i_clr && lvl_q == '0) |=> first_both_q == $past(i_both_sel))
    else $error("first-word port capture wrong");
  pkt_count_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pkt_in && !pkt_out && !i_clr) |=> pkts_q == $past(pkts_q) + 1)
    else $error("complete packet not counted");
  pr_pipe_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pkts_q == '0) |-> ##2 o_pr_pre)
    else $error("packet flag not released after two stages");
  ae_pipe_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (lvl_q < thr) |=> !o_ae_pre)
    else $error("almost-empty stage wrong below boundary");

endmodule : mqf_queue_flags
`default_nettype wire

// file: core/mqf_flag_logic.sv
// Status flag logic of a multi-queue flow-control device.
// How it works
// - Default offset 8 or 128 by select.
// - Active almost-empty falls two cycles after read.
// - Active almost-empty rises after skew plus one.
// - 36/36 boundary offset+2 or offset+1 writes.
// - 36 to narrow boundary offset+1 writes.
// - 18 to 36 boundary doubled.
// - 9 to 36 boundary quadrupled.
// - Bus bit falls two cycles after read.
// - Bus bit rises after skew plus one.
// - Read queue switch may add one cycle.
// - Packet-ready edges follow the read clock.
// - First end marker after start marker counts.
// - Packet-ready falls two after skew.
// - Packet-ready rises three after last start read.
// - Packet bus bits track the active flag.
// - Flag-mode low selects addressed almost-full bus.
// - Strobe plus matching identity takes the bus.
// - Bus shows new device one cycle later.
// - Queue bit may lag on coinciding access.
// - Packet mode picks read flag bus content.
// - Queue one to eight on bits zero-seven.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module mqf_flag_logic
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Master reset and straps
  input wire logic i_master_reset_n,
  input wire logic i_default_offset_select,
  input wire logic i_flag_bus_mode_select,
  input wire logic i_packet_mode_select,
  input wire mqf_pkg::mqf_width_t i_bus_width_mode,
  // Write port
  input wire logic i_wr_en,
  input wire logic i_wr_queue_sel,
  input wire logic [5:0] i_write_queue_address,
  input wire logic i_transmit_packet_start_marker,
  input wire logic i_transmit_packet_end_marker,
  // Read port
  input wire logic i_rd_en,
  input wire logic i_rd_queue_sel,
  input wire logic [mqf_pkg::QW-1:0] i_read_queue_address,
  input wire logic i_receive_packet_start_marker,
  // Almost-full bus selection
  input wire logic i_almost_full_bus_strobe,
  input wire logic [2:0] i_device_identity_inputs,
  input wire logic [mqf_pkg::NQ-1:0] i_queue_almost_full_n,
  // Flags
  output logic o_active_almost_empty_flag,
  output logic o_active_packet_ready_flag,
  output logic o_active_almost_full_flag,
  output logic [mqf_pkg::NQ-1:0] o_read_flag_bus,
  output logic [mqf_pkg::NQ-1:0] o_almost_full_flag_bus,
  output logic o_almost_full_flag_bus_oe,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  import mqf_pkg::*;

  logic df_q;
  logic fm_q;
  logic pkt_q;
  mqf_width_t width_q;
  logic [QW-1:0] wr_q_q;
  logic [QW-1:0] rd_q_q;
  logic [OFS_W-1:0] prog_offset_q;
  logic prog_loaded_q;
  logic [OFS_W-1:0] ae_offset;
  logic out36;
  logic [2:0] wr_units;
  logic [2:0] rd_units;
  logic [CNT_W-1:0] thr_wonly;
  logic [CNT_W-1:0] thr_both;
  logic [NQ-1:0] ae_pre;
  logic [NQ-1:0] pr_pre;
  logic af_sel_q;
  logic [31:0] status;
  logic avs_take;
  logic clr;

  assign clr = !i_master_reset_n;

  // ==========================================================
  // Straps, caught while master reset is held
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      df_q <= 1'b0;
      fm_q <= 1'b0;
      pkt_q <= 1'b0;
      width_q <= MQF_W36_36;
    end
    else if (clr)
    begin
      df_q <= i_default_offset_select;
      fm_q <= i_flag_bus_mode_select;
      pkt_q <= i_packet_mode_select;
      width_q <= i_bus_width_mode;
    end
  end

  // ==========================================================
  // Boundaries
  always_comb
  begin
    if (prog_loaded_q)
      ae_offset = prog_offset_q;
    else
      ae_offset = df_q ? OFS_HIGH : OFS_LOW;
  end

  always_comb
  begin
    out36 = 1'b0;
    wr_units = UNITS_36;
    rd_units = UNITS_36;
    unique case (width_q)
      MQF_W36_36: out36 = 1'b1;
      MQF_W36_18: rd_units = UNITS_18;
      MQF_W36_9: rd_units = UNITS_9;
      MQF_W18_36:
      begin
        out36 = 1'b1;
        wr_units = UNITS_18;
      end
      MQF_W9_36:
      begin
        out36 = 1'b1;
        wr_units = UNITS_9;
      end
      default: out36 = 1'b1;
    endcase
  end

  // Writes times write units is always four units per offset step,
  // so one shift covers the doubled and quadrupled boundaries.
  assign thr_wonly = (CNT_W'(ae_offset) + SLACK_WONLY) << 2;
  assign thr_both = out36 ? (CNT_W'(ae_offset) + SLACK_BOTH) << 2
                          : thr_wonly;

  // ==========================================================
  // Queue selection on both ports
  // A write in the cycle of a write queue switch lands in the old queue.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || clr)
      wr_q_q <= '0;
    else if (i_wr_queue_sel)
      wr_q_q <= i_write_queue_address[QW-1:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || clr)
      rd_q_q <= '0;
    else if (i_rd_queue_sel)
      rd_q_q <= i_read_queue_address;
  end

  // ==========================================================
  // Per-queue trackers
  for (genvar g = 0; g < NQ; g++)
  begin : g_queue
    mqf_queue_flags u_queue (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_clr(clr),
      .i_wr(i_wr_en && (wr_q_q == QW'(g))),
      .i_wr_units(wr_units),
      .i_sop_wr(i_transmit_packet_start_marker),
      .i_eop_wr(i_transmit_packet_end_marker),
      .i_both_sel(rd_q_q == QW'(g)),
      .i_rd(i_rd_en && (rd_q_q == QW'(g))),
      .i_rd_units(rd_units),
      .i_sop_rd(i_receive_packet_start_marker),
      .i_thr_both(thr_both),
      .i_thr_wonly(thr_wonly),
      .o_ae_pre(ae_pre[g]),
      .o_pr_pre(pr_pre[g])
    );
  end

  // ==========================================================
  // Read side flags
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_active_almost_empty_flag <= 1'b0;
      o_active_packet_ready_flag <= 1'b1;
    end
    else
    begin
      o_active_almost_empty_flag <= ae_pre[rd_q_q];
      o_active_packet_ready_flag <= pr_pre[rd_q_q];
    end
  end

  // A read queue switch freezes the bus for one cycle; the update
  // slips by a cycle instead of racing the selection change.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_read_flag_bus <= '0;
    else if (!i_rd_queue_sel)
      o_read_flag_bus <= pkt_q ? pr_pre : ae_pre;
  end

  // ==========================================================
  // Almost-full bus, driven in addressed mode only, and active almost-full flag
  // Selection and queue switch never share a cycle, so the strobe
  // decode need not arbitrate against the write queue path.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || clr)
      af_sel_q <= 1'b0;
    else if (i_almost_full_bus_strobe && !fm_q)
      af_sel_q <= (i_write_queue_address[5:3] ==
                   i_device_identity_inputs);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_almost_full_flag_bus <= '1;
      o_almost_full_flag_bus_oe <= 1'b0;
      o_active_almost_full_flag <= 1'b1;
    end
    else
    begin
      o_almost_full_flag_bus <= i_queue_almost_full_n;
      o_almost_full_flag_bus_oe <= af_sel_q && !fm_q;
      o_active_almost_full_flag <= i_queue_almost_full_n[wr_q_q];
    end
  end

  // ==========================================================
  // Avalon slave: every access answers on its second cycle
  assign avs_take = (i_avs_read || i_avs_write) && !o_avs_waitrequest;

  always_comb
  begin
    status = '0;
    status[STS_BUS_LSB +: NQ] = o_read_flag_bus;
    status[STS_ACT_LSB +: 3] = {o_active_almost_full_flag,
                                o_active_packet_ready_flag,
                                o_active_almost_empty_flag};
    status[STS_RDQ_LSB +: QW] = rd_q_q;
    status[STS_WRQ_LSB +: QW] = wr_q_q;
    status[STS_CFG_LSB +: 3] = {pkt_q, fm_q, df_q};
    status[STS_AFOE_BIT] = o_almost_full_flag_bus_oe;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_avs_waitrequest <= 1'b1;
    else
      o_avs_waitrequest <= !((i_avs_read || i_avs_write)
                             && o_avs_waitrequest);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_avs_readdata <= '0;
    else if (i_avs_read && o_avs_waitrequest)
    begin
      if (i_avs_address == REG_AE_OFFSET)
        o_avs_readdata <= {15'h0000, prog_loaded_q, prog_offset_q};
      else if (i_avs_address == REG_STATUS)
        o_avs_readdata <= status;
      else
        o_avs_readdata <= '0;
    end
  end

  // Master reset drops a programmed offset back to the strap default; an offset register write in the same cycle wins over it.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      prog_offset_q <= '0;
      prog_loaded_q <= 1'b0;
    end
    else if (avs_take && i_avs_write && i_avs_address == REG_AE_OFFSET)
    begin
      if (i_avs_byteenable[0])
        prog_offset_q[7:0] <= i_avs_writedata[7:0];
      if (i_avs_byteenable[1])
        prog_offset_q[15:8] <= i_avs_writedata[15:8];
      if (i_avs_byteenable[2])
        prog_loaded_q <= i_avs_writedata[OFS_LOADED_BIT];
    end
    else if (clr)
      prog_loaded_q <= 1'b0;
  end

  // ==========================================================
  // Checks
  df_default_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !prog_loaded_q |-> ae_offset == (df_q ? OFS_HIGH : OFS_LOW))
    else $error("default offset does not follow strap");
  af_take_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_almost_full_bus_strobe && !fm_q && i_master_reset_n
     && i_write_queue_address[5:3] == i_device_identity_inputs)
    |=> ##1 o_almost_full_flag_bus_oe)
    else $error("matching device did not take the bus");
  af_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_almost_full_bus_strobe && !fm_q
     && i_write_queue_address[5:3] != i_device_identity_inputs)
    |=> ##1 !o_almost_full_flag_bus_oe)
    else $error("deselected device still drives the bus");
  af_data_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_almost_full_flag_bus_oe |-> o_almost_full_flag_bus
      == $past(i_queue_almost_full_n))
    else $error("almost-full bus shows stale status");
  rd_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_rd_queue_sel |=> $stable(o_read_flag_bus))
    else $error("read flag bus moved during queue switch");
  bus_mode_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_rd_queue_sel |=> o_read_flag_bus
      == $past(pkt_q ? pr_pre : ae_pre))
    else $error("read flag bus shows wrong status kind");
  act_ae_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    1'b1 |=> o_active_almost_empty_flag == $past(ae_pre[rd_q_q]))
    else $error("active almost-empty flag off its queue");
  cfg_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_master_reset_n |=> $stable({df_q, fm_q, pkt_q, width_q}))
    else $error("straps changed outside master reset");
  avs_answer_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus access not answered in one cycle");

  pr_fall_c: cover property (@(posedge i_clk) $fell(o_active_packet_ready_flag));
  ae_rise_c: cover property (@(posedge i_clk) $rose(o_active_almost_empty_flag));
  af_take_c: cover property (@(posedge i_clk) $rose(o_almost_full_flag_bus_oe));
  avs_wr_c: cover property (@(posedge i_clk) avs_take && i_avs_write);

endmodule : mqf_flag_logic
`default_nettype wire

// file: bench/mqf_host_model.sv
// Host flow controller model driving the write and read ports.
`timescale 1ns/1ns
`default_nettype none
module mqf_host_model
(
  // Clock
  input wire logic i_clk,
  // Write port
  output logic o_wr_en,
  output logic o_wq_sel,
  output logic [5:0] o_waddr,
  output logic o_start_mk,
  output logic o_end_mk,
  output logic o_strobe,
  // Read port
  output logic o_rd_en,
  output logic o_rq_sel,
  output logic [2:0] o_raddr,
  output logic o_rd_start_mk
);
  // ============================================================
  // Idle levels
  initial
  begin
    {o_wr_en, o_wq_sel, o_waddr, o_start_mk, o_end_mk, o_strobe} = '0;
    {o_rd_en, o_rq_sel, o_raddr, o_rd_start_mk} = '0;
  end

  // ============================================================
  // Requests; each is entered right after a rising edge.
  task automatic put(input int n, input logic s, input logic e);
    for (int k = 0; k < n; k++)
    begin
      o_wr_en <= 1'b1;
      o_start_mk <= s;
      o_end_mk <= e;
      @(posedge i_clk);
    end
    o_wr_en <= 1'b0;
    o_start_mk <= ~s;
    o_end_mk <= 1'b0;
  endtask : put

  task automatic take(input logic s);
    o_rd_en <= 1'b1;
    o_rd_start_mk <= s;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_rd_start_mk <= ~s;
  endtask : take

  // A queue selection never shares a cycle with a bus strobe.
  task automatic wsel(input logic [2:0] q);
    o_wq_sel <= 1'b1;
    o_waddr <= {3'h0, q};
    @(posedge i_clk);
    o_wq_sel <= 1'b0;
    o_waddr <= ~o_waddr;
  endtask : wsel

  task automatic rsel(input logic [2:0] q);
    o_rq_sel <= 1'b1;
    o_raddr <= q;
    @(posedge i_clk);
    o_rq_sel <= 1'b0;
    o_raddr <= ~q;
  endtask : rsel

  // The device number rides in the top three address bits.
  task automatic strobe(input logic [2:0] dev);
    o_strobe <= 1'b1;
    o_waddr <= {dev, 3'h0};
    @(posedge i_clk);
    o_strobe <= 1'b0;
    o_waddr <= ~o_waddr;
  endtask : strobe
endmodule : mqf_host_model
`default_nettype wire

// file: bench/mqf_flag_logic_tb.sv
// Self-checking bench for the multi-queue status flag logic.
`timescale 1ns/1ns
`default_nettype none
module mqf_flag_logic_tb;
  import mqf_pkg::*;
  logic i_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mrst_n = 1'b1;
  logic dsel = 1'b0, fsel = 1'b0, psel = 1'b0;
  mqf_width_t wmode = MQF_W36_36;
  logic [7:0] af_n = 8'hff;
  logic [3:0] av_addr = 4'h0;
  logic av_rd = 1'b0, av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0, rdata, rd;
  logic [3:0] av_be = 4'hf;
  logic [2:0] dev_id = 3'h1;
  logic ae, pr, af, afoe, wait_rq;
  logic [7:0] rbus, afbus;
  logic wr_en, wq_sel, smk, emk, stb, rd_en, rq_sel, rsmk;
  logic [5:0] waddr;
  logic [2:0] raddr;
  wire logic [7:0] af_wire;
  int error_cnt = 0, tests_run = 0, cyc = 0;

  // The shared bus is taken to have pull-ups, so a released bus reads ones.
  assign af_wire = afoe ? afbus : 8'hff;
  always #2 i_clk = ~i_clk;

  mqf_host_model host (.i_clk(i_clk), .o_wr_en(wr_en), .o_wq_sel(wq_sel),
    .o_waddr(waddr), .o_start_mk(smk), .o_end_mk(emk), .o_strobe(stb),
    .o_rd_en(rd_en), .o_rq_sel(rq_sel), .o_raddr(raddr),
    .o_rd_start_mk(rsmk));

  mqf_flag_logic uut (.i_clk(i_clk), .i_sys_rst(sys_rst),
    .i_master_reset_n(mrst_n), .i_default_offset_select(dsel),
    .i_flag_bus_mode_select(fsel), .i_packet_mode_select(psel),
    .i_bus_width_mode(wmode), .i_wr_en(wr_en), .i_wr_queue_sel(wq_sel),
    .i_write_queue_address(waddr), .i_transmit_packet_start_marker(smk),
    .i_transmit_packet_end_marker(emk), .i_rd_en(rd_en),
    .i_rd_queue_sel(rq_sel), .i_read_queue_address(raddr),
    .i_receive_packet_start_marker(rsmk), .i_almost_full_bus_strobe(stb),
    .i_device_identity_inputs(dev_id), .i_queue_almost_full_n(af_n),
    .o_active_almost_empty_flag(ae), .o_active_packet_ready_flag(pr),
    .o_active_almost_full_flag(af), .o_read_flag_bus(rbus),
    .o_almost_full_flag_bus(afbus), .o_almost_full_flag_bus_oe(afoe),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .i_avs_byteenable(av_be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq));

  // ============================================================
  // Shared helpers
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic av_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    av_addr <= a;
    av_wdata <= d;
    av_wr <= 1'b1;
    @(posedge i_clk);
    while (wait_rq !== 1'b0)
      @(posedge i_clk);
    av_wr <= 1'b0;
  endtask : av_write

  task automatic av_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    av_addr <= a;
    av_rd <= 1'b1;
    @(posedge i_clk);
    while (wait_rq !== 1'b0)
      @(posedge i_clk);
    d = rdata;
    av_rd <= 1'b0;
  endtask : av_read

  task automatic mreset(input mqf_width_t m, input logic d, input logic f,
                        input logic p);
    @(posedge i_clk);
    wmode <= m;
    dsel <= d;
    fsel <= f;
    psel <= p;
    mrst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    mrst_n <= 1'b1;
    @(posedge i_clk);
  endtask : mreset

  // ============================================================
  // Scenarios
  // Fill queue q to one word short, then cross the boundary, and back when rq equals q.
  task automatic bound(input mqf_width_t m, input logic d, input logic [2:0] q,
    input logic [2:0] rq, input logic [15:0] ofs, input int n);
    mreset(m, d, 1'b0, 1'b0);
    dsel <= ~d;
    if (ofs != 16'h0)
      av_write(4'h0, {15'h0, 1'b1, ofs});
    @(posedge i_clk);
    host.wsel(q);
    @(posedge i_clk);
    host.rsel(rq);
    @(posedge i_clk);
    host.put(n - 1, 1'b0, 1'b0);
    repeat (3) @(posedge i_clk);
    #1 chk("bus short", 32'h0, rbus[q]);
    @(posedge i_clk);
    host.put(1, 1'b0, 1'b0);
    @(posedge i_clk);
    #1 chk("bus rise early", 32'h0, rbus[q]);
    @(posedge i_clk);
    #1 chk("bus rise", 32'h1, rbus[q]);
    if (q == rq)
    begin
      chk("act rise", 32'h1, ae);
      @(posedge i_clk);
      host.take(1'b0);
      @(posedge i_clk);
      #1 chk("act fall early", 32'h1, {rbus[q], ae} == 2'b11);
      @(posedge i_clk);
      #1 chk("act fall", 32'h0, ae);
      chk("bus fall", 32'h0, rbus[q]);
    end
  endtask : bound

  task automatic pkt_case();
    mreset(MQF_W36_36, 1'b0, 1'b0, 1'b1);
    host.put(1, 1'b0, 1'b1);
    repeat (4) @(posedge i_clk);
    #1 chk("lone end", 32'h1, pr);
    chk("pkt bus idle", 32'h1, rbus[0]);
    @(posedge i_clk);
    host.put(1, 1'b1, 1'b0);
    @(posedge i_clk);
    host.put(1, 1'b0, 1'b1);
    repeat (2) @(posedge i_clk);
    #1 chk("ready early", 32'h1, pr);
    @(posedge i_clk);
    #1 chk("ready", 32'h0, pr);
    chk("ready bus", 32'h0, rbus[0]);
    @(posedge i_clk);
    host.take(1'b1);
    repeat (2) @(posedge i_clk);
    #1 chk("drain early", 32'h0, pr);
    @(posedge i_clk);
    #1 chk("drain", 32'h1, {pr, rbus[0]} == 2'b11);
  endtask : pkt_case

  task automatic af_case();
    mreset(MQF_W36_36, 1'b0, 1'b1, 1'b0);
    host.strobe(3'h1);
    repeat (3) @(posedge i_clk);
    #1 chk("polled oe", 32'h0, afoe);
    mreset(MQF_W36_36, 1'b0, 1'b0, 1'b0);
    af_n <= 8'h5a;
    host.strobe(3'h1);
    #1 chk("sel early", 32'h0, afoe);
    @(posedge i_clk);
    #1 chk("sel bus", 32'h5a, af_wire);
    chk("act full low", 32'h0, af);
    @(posedge i_clk);
    af_n <= 8'ha5;
    repeat (2) @(posedge i_clk);
    #1 chk("bus follow", 32'ha5, af_wire);
    chk("act full", 32'h1, af);
    @(posedge i_clk);
    host.strobe(3'h2);
    #1 chk("desel early", 32'h1, afoe);
    @(posedge i_clk);
    #1 chk("released", 32'hff, {afoe, af_wire});
    @(posedge i_clk);
    dev_id <= 3'h5;
    host.strobe(3'h5);
    @(posedge i_clk);
    #1 chk("other id", 32'h1, afoe);
  endtask : af_case

  task automatic av_case();
    av_write(4'h0, 32'h0001_0003);
    av_read(4'h0, rd);
    chk("offset reg", 32'h0001_0003, rd);
    av_be <= 4'h1;
    av_write(4'h0, 32'h0000_02ff);
    av_be <= 4'hf;
    av_read(4'h0, rd);
    chk("byte lane", 32'h0001_00ff, rd);
    av_write(4'hc, 32'hffff_ffff);
    av_read(4'hc, rd);
    chk("unmapped", 32'h0, rd);
  endtask : av_case

  // ============================================================
  // Run
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end

  initial
  begin
    repeat (16) @(posedge i_clk);
    sys_rst <= 1'b0;
    #1 chk("reset oe", 32'h0, afoe);
    bound(MQF_W36_36, 1'b0, 3'h0, 3'h0, 16'h0, 10);
    bound(MQF_W36_36, 1'b1, 3'h2, 3'h1, 16'h0, 129);
    bound(MQF_W36_36, 1'b0, 3'h0, 3'h0, 16'h4, 6);
    bound(MQF_W36_18, 1'b0, 3'h0, 3'h0, 16'h0, 9);
    bound(MQF_W36_9, 1'b0, 3'h0, 3'h0, 16'h0, 9);
    bound(MQF_W18_36, 1'b0, 3'h0, 3'h0, 16'h0, 20);
    bound(MQF_W18_36, 1'b0, 3'h0, 3'h1, 16'h0, 18);
    bound(MQF_W9_36, 1'b0, 3'h0, 3'h0, 16'h0, 40);
    bound(MQF_W9_36, 1'b0, 3'h0, 3'h1, 16'h0, 36);
    pkt_case();
    af_case();
    av_case();
    close_out();
  end
endmodule : mqf_flag_logic_tb
`default_nettype wire
